// ==== common/cba_pkg.sv ====
// Purpose: shared constants and types for the context bank attribute bank
// Assumes: one clock, plain register port, 32-bit words
// Notes:   offsets are byte addresses
package cba_pkg;
    // ========================================================
    // register map
    localparam int          BANK_COUNT       = 128;
    localparam logic [11:0] ATTR_BASE        = 12'h000;
    localparam logic [11:0] ATTR_LAST        = 12'h1FC;
    localparam logic [11:0] CTRL_OFFSET      = 12'h400;
    localparam logic [11:0] STATUS_OFFSET    = 12'h404;
    localparam logic [31:0] ATTR_RESET       = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;
    // ========================================================
    // field positions
    localparam int IRQ_LSB    = 24;
    localparam int WALLOC_LSB = 22;
    localparam int RALLOC_LSB = 20;
    localparam int SHARE_LSB  = 18;
    localparam int TYPE_LSB   = 16;
    localparam int MEMA_LSB   = 12;
    localparam int BCAST_BIT  = 11;
    localparam int REGIME_BIT = 10;
    localparam int VMTAG_LSB  = 0;
    // control register bits
    localparam int CTRL_WIDE_VM   = 0;
    localparam int CTRL_VIRT_MODE = 1;
    localparam int CTRL_GS_ALIAS  = 2;
    // ========================================================
    // context types
    localparam logic [1:0] TYPE_S2_ONLY = 2'h0;
    localparam logic [1:0] TYPE_S1_BYP  = 2'h1;
    localparam logic [1:0] TYPE_S1_FLT  = 2'h2;
    localparam logic [1:0] TYPE_NESTED  = 2'h3;
    localparam logic [1:0] ALLOC_RSVD   = 2'h1;

    typedef struct packed {
        logic [7:0] irq_index;
        logic [1:0] write_alloc_cfg;
        logic [1:0] read_alloc_cfg;
        logic [1:0] barrier_share_upgrade;
        logic [1:0] ctx_type;
        logic [3:0] memory_attribute_code;
        logic       force_broadcast;
        logic       regime_select;
        logic [7:0] vm_identifier;
    } cba_attr_type;

    // per-transaction decode result
    typedef struct packed {
        logic       valid;
        logic       invalid_ctx_fault;
        logic       stage1_en;
        logic       stage2_en;
        logic       stall_retry;
        logic       hypervisor_context;
        logic       host_ext_context;
        logic       tag_vm;
        logic       tag_space_nonglobal;
        logic       force_broadcast;
        logic [7:0] irq_index;
        logic [7:0] vm_identifier;
        logic [1:0] write_alloc_cfg;
        logic [1:0] read_alloc_cfg;
        logic [1:0] barrier_share_upgrade;
        logic [3:0] memory_attribute_code;
    } cba_decode_type;
endpackage

// ==== design/cba_bank.sv ====
// Function
// - apply bank attributes only when mapping selects bank
// - secure bank with non-bypass type faults
// - write during stall retries as resume zero
// - unsupported stage type raises invalid context fault
// - type decode: s2, s1 bypass, fault, nested
// - single-stage bank type may be read-only
// - interrupt index selects context interrupt, limited
// - stage-2 layout reserved and zero fields
// - eight-bit vm tag unless wide tag enabled
// - bypass layout field placement
// - write allocate hint encoding, zero if unsupported
// - read allocate hint encoding, zero if unsupported
// - barrier upgrade encoding, zero if unsupported
// - force broadcast upgrades maintenance to inner shareable
// - hypervisor context tags without address or vm
// - host extension reuses regime bit when enabled
// - banks at consecutive words from offset zero
// - host extension tags with address space tag
//
// Purpose: attribute register bank and per-transaction context decode
// Assumes: plain register port, one clock, read data one cycle later
// Notes:   one lookup port; results registered one cycle after request
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module cba_bank #(
    parameter int         BANKS          = cba_pkg::BANK_COUNT,
    parameter int         IRQ_COUNT      = 128,
    parameter bit         SECURE_STATES  = 1'b1,
    parameter bit         NESTED_SUP     = 1'b1,
    parameter bit         S1_SUP         = 1'b1,
    parameter bit         S2_SUP         = 1'b1,
    parameter bit         HOST_EXT_SUP   = 1'b1,
    parameter bit         WALLOC_SUP     = 1'b1,
    parameter bit         RALLOC_SUP     = 1'b1,
    parameter bit         SHARE_SUP      = 1'b1,
    parameter bit         FIXED_TYPE     = 1'b0,
    parameter logic [1:0] FIXED_TYPE_VAL = 2'h0
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    // register port
    input  wire logic [11:0]           reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic [31:0]                reg_rdata,
    // per-bank security and stall state
    input  wire logic [BANKS-1:0]      bank_secure,
    input  wire logic [BANKS-1:0]      bank_stalled,
    // transaction lookup
    input  wire logic                  lookup_valid,
    input  wire logic                  lookup_is_bank,
    input  wire logic [6:0]            lookup_bank,
    output cba_pkg::cba_decode_type    lookup_result,
    // stall retry pulse
    output logic                       retry_valid,
    output logic [6:0]                 retry_bank
);
    // ========================================================
    // state
    typedef struct packed {
        cba_pkg::cba_attr_type [BANKS-1:0] attr;
        logic [31:0]                       ctrl;
        logic [31:0]                       rdata;
        cba_pkg::cba_decode_type           result;
        logic                              retry_valid;
        logic [6:0]                        retry_bank;
        logic [31:0]                       fault_count;
    } cba_state_type;

    cba_state_type         state;
    cba_state_type         next_state;
    cba_pkg::cba_attr_type wr_fields;
    logic [31:0]           bank_view [BANKS];
    logic [31:0]           rd_word;
    logic [6:0]            wr_index;
    logic                  wr_attr;
    logic                  wide_vm;
    logic                  virt_mode;

    assign wide_vm   = state.ctrl[cba_pkg::CTRL_WIDE_VM];
    assign virt_mode = state.ctrl[cba_pkg::CTRL_VIRT_MODE];
    assign wr_index  = reg_addr[8:2];
    // bank registers are word-aligned from zero
    assign wr_attr   = reg_write && (reg_addr <= cba_pkg::ATTR_LAST)
                       && (reg_addr[1:0] == 2'h0)
                       && (32'(wr_index) < 32'(BANKS));

    // ========================================================
    // write path and read views
    cba_field_filter #(
        .WALLOC_SUP     (WALLOC_SUP),
        .RALLOC_SUP     (RALLOC_SUP),
        .SHARE_SUP      (SHARE_SUP),
        .FIXED_TYPE     (FIXED_TYPE),
        .FIXED_TYPE_VAL (FIXED_TYPE_VAL)
    ) u_filter (
        .wdata  (reg_wdata),
        .fields (wr_fields)
    );

    for (genvar b = 0; b < BANKS; b++) begin : g_view
        cba_read_format u_fmt (
            .fields             (state.attr[b]),
            .wide_vm_tag_enable (wide_vm),
            .rdata              (bank_view[b])
        );
    end

    // ========================================================
    // read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        if (reg_addr <= cba_pkg::ATTR_LAST) begin
            if (32'(wr_index) < 32'(BANKS)) begin
                rd_word = bank_view[wr_index];
            end
        end else if (reg_addr == cba_pkg::CTRL_OFFSET) begin
            rd_word = state.ctrl;
        end else if (reg_addr == cba_pkg::STATUS_OFFSET) begin
            rd_word = state.fault_count;
        end
    end

    // ========================================================
    // context decode for one transaction
    function automatic cba_pkg::cba_decode_type decode(
        input cba_pkg::cba_attr_type a,
        input logic                  secure,
        input logic                  wide,
        input logic                  vmode
    );
        cba_pkg::cba_decode_type d;
        logic host_ext;
        d = '0;
        host_ext = HOST_EXT_SUP && vmode;
        d.valid = 1'b1;
        unique case (a.ctx_type)
            cba_pkg::TYPE_S2_ONLY: begin
                d.stage2_en = 1'b1;
                d.invalid_ctx_fault = !S2_SUP;
            end
            cba_pkg::TYPE_S1_BYP: begin
                d.stage1_en = 1'b1;
                d.invalid_ctx_fault = !S1_SUP;
            end
            cba_pkg::TYPE_S1_FLT: begin
                d.invalid_ctx_fault = 1'b1;
            end
            cba_pkg::TYPE_NESTED: begin
                d.stage1_en = 1'b1;
                d.stage2_en = 1'b1;
                d.invalid_ctx_fault = !NESTED_SUP;
            end
        endcase
        if (SECURE_STATES && secure
            && a.ctx_type != cba_pkg::TYPE_S1_BYP) begin
            d.invalid_ctx_fault = 1'b1;
        end
        // irq index beyond implemented count clamps to top
        d.irq_index = (32'(a.irq_index) < 32'(IRQ_COUNT)) ? a.irq_index
                      : 8'(IRQ_COUNT - 1);
        d.vm_identifier = wide ? 8'h00 : a.vm_identifier;
        d.tag_vm = !wide;
        d.tag_space_nonglobal = 1'b1;
        if (a.ctx_type == cba_pkg::TYPE_S1_BYP) begin
            d.write_alloc_cfg = a.write_alloc_cfg;
            d.read_alloc_cfg = a.read_alloc_cfg;
            d.barrier_share_upgrade = a.barrier_share_upgrade;
            d.memory_attribute_code = a.memory_attribute_code;
            d.force_broadcast = a.force_broadcast;
            if (a.regime_select && host_ext) begin
                d.host_ext_context = 1'b1;
                d.tag_vm = 1'b0;
                d.tag_space_nonglobal = 1'b1;
            end else if (a.regime_select) begin
                d.hypervisor_context = 1'b1;
                d.tag_vm = 1'b0;
                d.tag_space_nonglobal = 1'b0;
                d.vm_identifier = 8'h00;
            end
        end
        // reserved allocation code falls back to default
        if (d.write_alloc_cfg == cba_pkg::ALLOC_RSVD) begin
            d.write_alloc_cfg = 2'h0;
        end
        if (d.read_alloc_cfg == cba_pkg::ALLOC_RSVD) begin
            d.read_alloc_cfg = 2'h0;
        end
        // secure hyp+monitor+wide combos (software's duty) not checked
        return d;
    endfunction

    // ========================================================
    // next state
    always_comb begin
        next_state = state;
        next_state.retry_valid = 1'b0;
        next_state.result.valid = 1'b0;
        if (reg_read) begin
            next_state.rdata = rd_word;
        end
        if (wr_attr) begin
            next_state.attr[wr_index] = wr_fields;
            if (bank_stalled[wr_index]) begin
                next_state.retry_valid = 1'b1;
                next_state.retry_bank = wr_index;
            end
        end
        if (reg_write && reg_addr == cba_pkg::CTRL_OFFSET) begin
            next_state.ctrl = {29'h0, reg_wdata[2:0]};
        end
        // only mapped bank lookups use the attributes
        if (lookup_valid && lookup_is_bank
            && 32'(lookup_bank) < 32'(BANKS)) begin
            next_state.result = decode(state.attr[lookup_bank],
                                       bank_secure[lookup_bank],
                                       wide_vm, virt_mode);
            if (next_state.result.invalid_ctx_fault) begin
                next_state.fault_count = state.fault_count + 32'h1;
            end
        end
    end

    // ========================================================
    // registers; clock enable freezes everything
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < BANKS; i++) begin
                state.attr[i]          <= '0;
                // a read-only type reads its fixed value
                state.attr[i].ctx_type <= FIXED_TYPE ? FIXED_TYPE_VAL
                    : cba_pkg::ATTR_RESET[cba_pkg::TYPE_LSB +: 2];
            end
            state.ctrl        <= cba_pkg::CTRL_RESET;
            state.rdata       <= 32'h0000_0000;
            state.result      <= '0;
            state.retry_valid <= 1'b0;
            state.retry_bank  <= 7'h00;
            state.fault_count <= 32'h0000_0000;
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign reg_rdata     = state.rdata;
    assign lookup_result = state.result;
    assign retry_valid   = state.retry_valid;
    assign retry_bank    = state.retry_bank;
endmodule // cba_bank

// ==== design/cba_field_filter.sv ====
// Purpose: masks a written attribute word into the stored fields
// Assumes: feature straps are constant parameters
// Notes:   unsupported fields read zero and drop writes
`timescale 1ns/1ps
module cba_field_filter #(
    parameter bit WALLOC_SUP = 1'b1,
    parameter bit RALLOC_SUP = 1'b1,
    parameter bit SHARE_SUP  = 1'b1,
    parameter bit FIXED_TYPE = 1'b0,
    parameter logic [1:0] FIXED_TYPE_VAL = 2'h0
) (
    // raw word
    input  wire logic [31:0]          wdata,
    // filtered fields
    output cba_pkg::cba_attr_type     fields
);
    // ========================================================
    // field extraction
    always_comb begin
        fields.irq_index = wdata[cba_pkg::IRQ_LSB +: 8];
        fields.write_alloc_cfg = WALLOC_SUP ?
            wdata[cba_pkg::WALLOC_LSB +: 2] : 2'h0;
        fields.read_alloc_cfg = RALLOC_SUP ?
            wdata[cba_pkg::RALLOC_LSB +: 2] : 2'h0;
        fields.barrier_share_upgrade = SHARE_SUP ?
            wdata[cba_pkg::SHARE_LSB +: 2] : 2'h0;
        // fixed type costs no storage
        fields.ctx_type = FIXED_TYPE ? FIXED_TYPE_VAL
            : wdata[cba_pkg::TYPE_LSB +: 2];
        fields.memory_attribute_code = wdata[cba_pkg::MEMA_LSB +: 4];
        fields.force_broadcast = wdata[cba_pkg::BCAST_BIT];
        fields.regime_select   = wdata[cba_pkg::REGIME_BIT];
        fields.vm_identifier   = wdata[cba_pkg::VMTAG_LSB +: 8];
    end
endmodule // cba_field_filter

// ==== design/cba_read_format.sv ====
// Purpose: builds the read view of one attribute word by type layout
// Assumes: stored fields already filtered
// Notes:   reserved positions always read zero
`timescale 1ns/1ps
module cba_read_format (
    // stored fields
    input  cba_pkg::cba_attr_type fields,
    input  wire logic             wide_vm_tag_enable,
    // read view
    output logic [31:0]           rdata
);
    // ========================================================
    // layout select
    always_comb begin
        rdata = 32'h0000_0000;
        rdata[cba_pkg::IRQ_LSB +: 8]  = fields.irq_index;
        rdata[cba_pkg::TYPE_LSB +: 2] = fields.ctx_type;
        if (!wide_vm_tag_enable) begin
            rdata[cba_pkg::VMTAG_LSB +: 8] = fields.vm_identifier;
        end
        if (fields.ctx_type == cba_pkg::TYPE_S1_BYP) begin
            rdata[cba_pkg::WALLOC_LSB +: 2] = fields.write_alloc_cfg;
            rdata[cba_pkg::RALLOC_LSB +: 2] = fields.read_alloc_cfg;
            rdata[cba_pkg::SHARE_LSB +: 2] = fields.barrier_share_upgrade;
            rdata[cba_pkg::MEMA_LSB +: 4] = fields.memory_attribute_code;
            rdata[cba_pkg::BCAST_BIT]  = fields.force_broadcast;
            rdata[cba_pkg::REGIME_BIT] = fields.regime_select;
        end
        // stage-2-only: 23:20, 19:18 and 15:8 stay zero
    end
endmodule // cba_read_format

// ==== testbench/cba_bank_assertions.sv ====
// Purpose: port-level checks for the context bank attribute bank
// Assumes: one clock domain, fixed one-cycle answers
// Notes:   bound onto every cba_bank instance
`timescale 1ns/1ps
module cba_bank_checker #(
    parameter int BANKS     = cba_pkg::BANK_COUNT,
    parameter int IRQ_COUNT = 128
) (
    // clock and reset
    input wire logic               clock,
    input wire logic               sys_rst,
    input wire logic               clk_en,
    // register port
    input wire logic [11:0]        reg_addr,
    input wire logic [31:0]        reg_wdata,
    input wire logic               reg_write,
    input wire logic               reg_read,
    input wire logic [31:0]        reg_rdata,
    // bank state
    input wire logic [BANKS-1:0]   bank_secure,
    input wire logic [BANKS-1:0]   bank_stalled,
    // lookup and retry
    input wire logic               lookup_valid,
    input wire logic               lookup_is_bank,
    input wire logic [6:0]         lookup_bank,
    input cba_pkg::cba_decode_type lookup_result,
    input wire logic               retry_valid,
    input wire logic [6:0]         retry_bank
);
    // ==========================================================
    // helpers
    logic [6:0] wr_bank;
    logic       attr_wr;
    logic       stall_wr;
    assign wr_bank  = reg_addr[8:2];
    assign attr_wr  = clk_en && reg_write && reg_addr <= cba_pkg::ATTR_LAST
                      && reg_addr[1:0] == 2'h0;
    assign stall_wr = attr_wr && bank_stalled[wr_bank];

    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // checks
    AST_RETRY_STALLED: assert property (
        stall_wr |=> retry_valid && retry_bank == $past(wr_bank))
        else $error("no retry after write to stalled bank");
    AST_RETRY_QUIET: assert property (
        clk_en && !stall_wr |=> !retry_valid)
        else $error("retry without stalled write");
    AST_LOOKUP_ANSWER: assert property (
        clk_en && lookup_valid && lookup_is_bank |=> lookup_result.valid)
        else $error("bank lookup got no result");
    AST_LOOKUP_NONE: assert property (
        clk_en && !(lookup_valid && lookup_is_bank)
        |=> !lookup_result.valid)
        else $error("result without bank lookup");
    AST_UNMAPPED_ZERO: assert property (
        clk_en && reg_read && reg_addr inside {[12'h200:12'h3FC]}
        |=> reg_rdata == 32'h0)
        else $error("reserved range read not zero");
    AST_RDATA_HOLD: assert property (
        !(clk_en && reg_read) |=> $stable(reg_rdata))
        else $error("read data moved without read");
    AST_STAGE_OR_FAULT: assert property (
        lookup_result.valid |-> lookup_result.invalid_ctx_fault
        || lookup_result.stage1_en || lookup_result.stage2_en)
        else $error("result with no stage and no fault");
    AST_HYP_UNTAGGED: assert property (
        lookup_result.valid && lookup_result.hypervisor_context
        |-> !lookup_result.tag_vm && !lookup_result.tag_space_nonglobal)
        else $error("hypervisor context carries tags");
    AST_HOST_EXT: assert property (
        lookup_result.valid && lookup_result.host_ext_context
        |-> !lookup_result.hypervisor_context)
        else $error("host extension and hypervisor both set");
    AST_IRQ_RANGE: assert property (
        lookup_result.valid |-> lookup_result.irq_index < IRQ_COUNT)
        else $error("interrupt index beyond count");

    // ==========================================================
    // coverage
    COV_STALL_WR: cover property (stall_wr);
    COV_FAULT: cover property (lookup_result.valid
        && lookup_result.invalid_ctx_fault);
    COV_HOST_EXT: cover property (lookup_result.valid
        && lookup_result.host_ext_context);
endmodule // cba_bank_checker

bind cba_bank cba_bank_checker #(.BANKS(BANKS), .IRQ_COUNT(IRQ_COUNT))
    chk_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .bank_secure(bank_secure), .bank_stalled(bank_stalled),
    .lookup_valid(lookup_valid), .lookup_is_bank(lookup_is_bank),
    .lookup_bank(lookup_bank), .lookup_result(lookup_result),
    .retry_valid(retry_valid), .retry_bank(retry_bank));

// ==== testbench/cba_bank_bench.sv ====
// Purpose: self-checking bench for the context bank attribute bank
// Assumes: default parameters, non-secure banks unless a test says
// Notes:   clk_en drops only in the freeze test
`timescale 1ns/1ps
module cba_bank_bench;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [31:0] rview;
        logic        rd_chk;
        logic        fault;
        logic        s1;
    } cba_row_type;

    logic                    clock;
    logic                    sys_rst;
    logic                    clk_en;
    logic [11:0]             reg_addr;
    logic [31:0]             reg_wdata;
    logic                    reg_write;
    logic                    reg_read;
    logic [31:0]             reg_rdata;
    logic [127:0]            bank_secure;
    logic [127:0]            bank_stalled;
    logic                    lookup_valid;
    logic                    lookup_is_bank;
    logic [6:0]              lookup_bank;
    cba_pkg::cba_decode_type lookup_result;
    logic                    retry_valid;
    logic [6:0]              retry_bank;
    cba_pkg::cba_decode_type res;
    logic [31:0]             rv;
    int                      err_total;
    int                      samples_checked;
    cba_row_type             rows [6];

    cba_bank dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata),
        .bank_secure(bank_secure), .bank_stalled(bank_stalled),
        .lookup_valid(lookup_valid), .lookup_is_bank(lookup_is_bank),
        .lookup_bank(lookup_bank), .lookup_result(lookup_result),
        .retry_valid(retry_valid), .retry_bank(retry_bank));

    // ==========================================================
    // bus tasks
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic look(input logic [6:0] b, input logic is_bank,
                        output cba_pkg::cba_decode_type r);
        @(posedge clock);
        lookup_valid   <= 1'b1;
        lookup_is_bank <= is_bank;
        lookup_bank    <= b;
        @(posedge clock);
        lookup_valid <= 1'b0;
        #1 r = lookup_result;
    endtask
    task automatic summarize();
        if (err_total == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // clock, reset, watchdog
    initial clock = 1'b0;
    always #2.5 clock = ~clock;
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        summarize();
    end

    // ==========================================================
    // main sequence
    initial begin
        {reg_addr, reg_wdata, reg_write, reg_read} = '0;
        {bank_secure, bank_stalled} = '0;
        {lookup_valid, lookup_is_bank, lookup_bank} = '0;
        err_total = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        // addr, write, read view, view checked, fault, stage 1
        rows[0] = {12'h000, 32'h2AFC_00C3, 32'h2A00_00C3, 3'b100};
        rows[1] = {12'h004, 32'h12FD_FFC3, 32'h12FD_FCC3, 3'b101};
        rows[2] = {12'h1FC, 32'h0165_A855, 32'h0165_A855, 3'b101};
        rows[3] = {12'h008, 32'h7F99_0300, 32'h7F99_0000, 3'b101};
        rows[4] = {12'h00C, 32'h0502_0000, 32'h0, 3'b010};
        rows[5] = {12'h010, 32'h0603_0000, 32'h0, 3'b001};
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        rd(12'h000, rv);
        chk("attr reset", rv, cba_pkg::ATTR_RESET);
        rd(cba_pkg::CTRL_OFFSET, rv);
        chk("ctrl reset", rv, cba_pkg::CTRL_RESET);
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].addr, rv);
            if (rows[i].rd_chk) chk("view", rv, rows[i].rview);
            look(rows[i].addr[8:2], 1'b1, res);
            chk("fault", res.invalid_ctx_fault, rows[i].fault);
            if (!rows[i].fault)
                chk("stage1", res.stage1_en, rows[i].s1);
            chk("irq", res.irq_index, rows[i].wdata[31:24]);
        end
        // reserved range and unaligned writes are dropped
        wr(12'h200, 32'hFFFF_FFFF);
        rd(12'h200, rv);
        chk("unmapped", rv, 32'h0);
        wr(12'h002, 32'hFFFF_FFFF);
        rd(12'h000, rv);
        chk("unaligned", rv, 32'h2A00_00C3);
        // wide tag hides the eight-bit tag
        wr(cba_pkg::CTRL_OFFSET, 32'h1);
        rd(12'h004, rv);
        chk("wide tag", rv, 32'h12FD_FC00);
        wr(cba_pkg::CTRL_OFFSET, 32'h0);
        // regime bit and broadcast
        look(7'h01, 1'b1, res);
        chk("hyp", res.hypervisor_context, 1'b1);
        chk("bcast on", res.force_broadcast, 1'b1);
        look(7'h02, 1'b1, res);
        chk("bcast off", res.force_broadcast, 1'b0);
        wr(cba_pkg::CTRL_OFFSET, 32'h2);
        look(7'h01, 1'b1, res);
        chk("host ext", res.host_ext_context, 1'b1);
        chk("hyp off", res.hypervisor_context, 1'b0);
        chk("space tag", res.tag_space_nonglobal, 1'b1);
        // alias on first: bank 1 keeps its hyp bit once secure
        wr(cba_pkg::CTRL_OFFSET, 32'h4);
        // secure banks must use the bypass type
        @(posedge clock);
        // no monitor or wide-va bits exist in this bank
        bank_secure[1:0] <= 2'h3;
        look(7'h00, 1'b1, res);
        chk("sec s2", res.invalid_ctx_fault, 1'b1);
        look(7'h01, 1'b1, res);
        chk("sec byp", res.invalid_ctx_fault, 1'b0);
        look(7'h01, 1'b0, res);
        chk("no bank", res.valid, 1'b0);
        // one type-10 bank and one secure stage-2 bank so far
        rd(cba_pkg::STATUS_OFFSET, rv);
        chk("fault count", rv, 32'h2);
        // write to a stalled bank retries it
        @(posedge clock);
        bank_stalled[3] <= 1'b1;
        wr(12'h00C, 32'h0001_0000);
        #1 chk("retry", retry_valid, 1'b1);
        chk("retry bank", retry_bank, 7'h03);
        wr(12'h010, 32'h0001_0000);
        #1 chk("no retry", retry_valid, 1'b0);
        // a write while frozen must not land
        @(posedge clock);
        clk_en <= 1'b0;
        wr(12'h014, 32'hFF00_0000);
        clk_en <= 1'b1;
        rd(12'h014, rv);
        chk("frozen", rv, cba_pkg::ATTR_RESET);
        // index beyond 128 interrupts clamps to the top one
        wr(12'h014, 32'hFF00_0000);
        look(7'h05, 1'b1, res);
        chk("irq clamp", res.irq_index, 8'h7F);
        // second reset clears stored attributes
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(12'h004, rv);
        chk("rereset", rv, cba_pkg::ATTR_RESET);
        summarize();
    end
endmodule // cba_bank_bench
